// ==== pkg/ssf_cfg.svh ====
// Register map, field positions, reset values and codes of the sample buffer.
// Assumes it is included by bare name from the package and the design file.
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH

// Register offsets on the internal host register port.
`define SSF_ADDR_WTM_TH      8'h13
`define SSF_ADDR_CTRL        8'h14
`define SSF_ADDR_CNT_LOW     8'h15
`define SSF_ADDR_STATUS      8'h16
`define SSF_ADDR_DATA_OUT    8'h17

// Control register fields.
`define SSF_CTRL_RD_MODE_BIT 7
`define SSF_CTRL_SIZE_HI     3
`define SSF_CTRL_SIZE_LO     2
`define SSF_CTRL_POL_HI      1
`define SSF_CTRL_POL_LO      0

// Status register fields.
`define SSF_STAT_FULL_BIT    7
`define SSF_STAT_WTM_BIT     6
`define SSF_STAT_OVR_BIT     5
`define SSF_STAT_NEMPTY_BIT  4
`define SSF_STAT_CNT_HI      1
`define SSF_STAT_CNT_LO      0

// Reset values.
`define SSF_RST_WTM          8'h00
`define SSF_RST_SIZE         2'h0
`define SSF_RST_POLICY       2'h0
`define SSF_RST_BYTE         8'h00

// Policy codes.
`define SSF_POL_BYPASS       2'h0
`define SSF_POL_FILL_ONCE    2'h1
`define SSF_POL_STREAM       2'h2
`define SSF_POL_RESERVED     2'h3

// Depth codes and their capacities in samples.
`define SSF_SIZE_16          2'h0
`define SSF_SIZE_32          2'h1
`define SSF_SIZE_64          2'h2
`define SSF_SIZE_128         2'h3
`define SSF_SAMPLES_16       16
`define SSF_SAMPLES_32       32
`define SSF_SAMPLES_64       64
`define SSF_SAMPLES_128      128

// Word count width and skid buffer depth.
`define SSF_CNT_W            10
`define SSF_SKID_DEPTH       2

`endif

// ==== pkg/ssf_pkg.sv ====
// Types shared by the sample buffer design and its bench.
// Assumes ssf_cfg.svh is on the include path.
`include "ssf_cfg.svh"

package ssf_pkg;
   typedef logic [7:0]              ssf_byte_t;
   typedef logic [15:0]             ssf_word_t;
   typedef logic [1:0]              ssf_field2_t;
   typedef logic [`SSF_CNT_W-1:0]   ssf_count_t;
endpackage

// ==== hdl/ssf_sample_fifo.sv ====
// Sample buffer control, status and byte readout of a motion sensor.
// Assumes the host interface decoder turns serial accesses into one-cycle
// read and write strobes with an 8-bit address, and that the command engine
// pulses a request when the host asks for buffer readout.
`timescale 1ns/1ns
`include "ssf_cfg.svh"

// Overview of operation
// R1: An 8-bit watermark threshold register holds the sample count that raises watermark.
// R2: Readout bit low means write mode; enabled sensor words are stored.
// R3: Readout bit high means read mode; data leaves through the byte data register.
// R4: The command engine request sets the readout bit by itself.
// R5: Host writes zero to the readout bit when it has finished reading.
// R6: Storing resumes only once the host has cleared the readout bit.
// R7: Depth field 00/01/10/11 gives 16/32/64/128 samples of capacity.
// R8: Policy field 00 bypass, 01 fill-once, 10 streaming, 11 reserved.
// R9: Count register shows low eight bits of the word count in 2-byte words.
// R10: Status bits 1:0 show the upper two bits of the word count.
// R11: Status bit 7 is high exactly while the buffer is full.
// R12: Status bit 6 is set when the level reaches a nonzero watermark threshold.
// R13: Status bit 5 is set when fill-once drops an incoming word or streaming evicts the oldest word.
// R14: Status bit 4 is high while the buffer holds at least one entry.
// R15: Data register at 0x17 presents buffered content one byte at a time.
// R16: Command completion shows on interrupt line one or the done status output, by select.
// R17: Each data register read in read mode with data buffered removes one byte; every second one updates count and flags.
// R18: Fill-once stops storing when full; streaming drops the oldest word.
module ssf_sample_fifo
   import ssf_pkg::*;
#(
   parameter int WORDS_PER_SAMPLE = 6
)(
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   // Host register port.
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic        reg_wr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_rd_in,
   output logic      [7:0]  reg_rdata_out,
   // Sensor word stream.
   input  wire logic        word_valid_in,
   input  wire logic [15:0] word_data_in,
   output logic             word_ready_out,
   // Command engine handshake.
   input  wire logic        cmd_rd_mode_in,
   input  wire logic        cmd_done_clr_in,
   input  wire logic        handshake_sel_in,
   output logic             interrupt_line_one_out,
   output logic             cmd_done_status_out
);

   localparam int MEM_WORDS = `SSF_SAMPLES_128 * WORDS_PER_SAMPLE;
   localparam int PTR_W     = $clog2(MEM_WORDS);

   // Capacity in words for a depth code.
   function automatic ssf_count_t cap_words(input ssf_field2_t size);
      int samples;
      samples = `SSF_SAMPLES_16;
      case (size)
         `SSF_SIZE_16:  samples = `SSF_SAMPLES_16;
         `SSF_SIZE_32:  samples = `SSF_SAMPLES_32;
         `SSF_SIZE_64:  samples = `SSF_SAMPLES_64;
         `SSF_SIZE_128: samples = `SSF_SAMPLES_128;
         default:       samples = `SSF_SAMPLES_16;
      endcase
      return ssf_count_t'(samples * WORDS_PER_SAMPLE); // see R7
   endfunction

   // Next memory index with wrap at the physical end.
   function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
      if (int'(p) == MEM_WORDS - 1) begin
         return '0;
      end
      return p + PTR_W'(1);
   endfunction

   // Register state.
   ssf_byte_t        wtm_q;
   logic             rd_mode_q;
   ssf_field2_t      size_q;
   ssf_field2_t      policy_q;
   ssf_byte_t        data_out_q;
   logic             overrun_q;
   logic             cmd_done_q;

   // Buffer state.
   ssf_word_t        mem [MEM_WORDS];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   ssf_count_t       count_q;
   logic             byte_sel_q;

   // Skid buffer state.
   ssf_word_t        skid_mem [`SSF_SKID_DEPTH];
   logic             skid_wr_q;
   logic             skid_rd_q;
   logic [1:0]       skid_cnt_q;

   // Decoded strobes and derived status.
   logic             wr_ctrl;
   logic             flush;
   logic             rd_data;
   logic             pop_byte;
   logic             pop_word;
   logic             skid_push;
   logic             skid_valid;
   logic             drain;
   logic             store;
   logic             drop;
   logic             evict;
   logic             full;
   logic             not_empty;
   logic             wtm_hit;
   ssf_count_t       cap;
   logic [11:0]      wtm_words;
   ssf_word_t        head_word;
   ssf_byte_t        head_byte;
   ssf_byte_t        status_byte;
   ssf_byte_t        ctrl_byte;

   // Host strobes. Changing depth or policy flushes, since stale pointers
   // could otherwise exceed a smaller capacity.
   assign wr_ctrl  = reg_wr_in && (reg_addr_in == `SSF_ADDR_CTRL);
   assign flush    = wr_ctrl && ((reg_wdata_in[`SSF_CTRL_SIZE_HI:`SSF_CTRL_SIZE_LO] != size_q) ||
                                 (reg_wdata_in[`SSF_CTRL_POL_HI:`SSF_CTRL_POL_LO] != policy_q));
   assign rd_data  = reg_rd_in && (reg_addr_in == `SSF_ADDR_DATA_OUT);
   assign pop_byte = rd_data && rd_mode_q && (count_q != '0); // see R3
   assign pop_word = pop_byte && byte_sel_q; // see R17

   // Level flags derived from the word count.
   assign cap       = cap_words(size_q);
   assign full      = (count_q >= cap); // see R11
   assign not_empty = (count_q != '0); // see R14
   assign wtm_words = 12'(int'(wtm_q) * WORDS_PER_SAMPLE);
   assign wtm_hit   = (wtm_q != '0) && ({2'h0, count_q} >= wtm_words); // see R12

   // Low byte goes out first, then the high byte of the head word.
   assign head_word = mem[rd_ptr_q];
   assign head_byte = byte_sel_q ? head_word[15:8] : head_word[7:0]; // see R15

   // Skid buffer handshake: it drains only in write mode, so readout
   // back-pressures the sensor stream instead of losing words.
   assign skid_valid     = (skid_cnt_q != 2'h0);
   assign word_ready_out = (skid_cnt_q != 2'(`SSF_SKID_DEPTH));
   assign skid_push      = word_valid_in && word_ready_out;
   assign drain          = skid_valid && !rd_mode_q && !flush; // see R2, R6

   // Placement of a drained word according to the policy.
   always_comb begin
      store = 1'b0;
      drop  = 1'b0;
      evict = 1'b0;
      if (drain) begin
         case (policy_q)
            `SSF_POL_FILL_ONCE: begin
               store = !full;
               drop  = full; // see R18
            end
            `SSF_POL_STREAM: begin
               store = 1'b1;
               evict = full; // see R18
            end
            default: begin
               store = 1'b0; // see R8
            end
         endcase
      end
   end

   // Watermark threshold register.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wtm_q <= `SSF_RST_WTM;
      end else if (reg_wr_in && (reg_addr_in == `SSF_ADDR_WTM_TH)) begin
         wtm_q <= reg_wdata_in; // see R1
      end
   end

   // Depth and policy fields.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         size_q   <= `SSF_RST_SIZE;
         policy_q <= `SSF_RST_POLICY;
      end else if (wr_ctrl) begin
         size_q   <= reg_wdata_in[`SSF_CTRL_SIZE_HI:`SSF_CTRL_SIZE_LO]; // see R7
         policy_q <= reg_wdata_in[`SSF_CTRL_POL_HI:`SSF_CTRL_POL_LO]; // see R8
      end
   end

   // Readout bit: set by the command engine, cleared only by a host write
   // of zero. A host write of one is ignored. The command wins a collision.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_mode_q <= 1'b0;
      end else if (cmd_rd_mode_in) begin
         rd_mode_q <= 1'b1; // see R4
      end else if (wr_ctrl && !reg_wdata_in[`SSF_CTRL_RD_MODE_BIT]) begin
         rd_mode_q <= 1'b0; // see R5, R6
      end
   end

   // Command completion flag, routed by the handshake select.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cmd_done_q <= 1'b0;
      end else if (cmd_rd_mode_in) begin
         cmd_done_q <= 1'b1; // see R16
      end else if (cmd_done_clr_in) begin
         cmd_done_q <= 1'b0;
      end
   end

   assign interrupt_line_one_out = cmd_done_q && !handshake_sel_in; // see R16
   assign cmd_done_status_out    = cmd_done_q && handshake_sel_in; // see R16

   // Overrun flag: sticky, cleared by a status read or a flush. A new
   // drop in the clearing cycle keeps it set so no event is lost.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         overrun_q <= 1'b0;
      end else if (drop || evict) begin
         overrun_q <= 1'b1; // see R13
      end else if (flush || (reg_rd_in && (reg_addr_in == `SSF_ADDR_STATUS))) begin
         overrun_q <= 1'b0;
      end
   end

   // Sample memory; no reset needed since the count guards every read.
   always_ff @(posedge clk_in) begin
      if (store) begin
         mem[wr_ptr_q] <= skid_mem[skid_rd_q];
      end
   end

   // Write pointer.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wr_ptr_q <= '0;
      end else if (flush) begin
         wr_ptr_q <= '0;
      end else if (store) begin
         wr_ptr_q <= ptr_next(wr_ptr_q); // see R2
      end
   end

   // Read pointer: advances on a fully read word or on a streaming eviction.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_ptr_q <= '0;
      end else if (flush) begin
         rd_ptr_q <= '0;
      end else if (pop_word || evict) begin
         rd_ptr_q <= ptr_next(rd_ptr_q); // see R17, R18
      end
   end

   // Byte select inside the head word.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         byte_sel_q <= 1'b0;
      end else if (flush) begin
         byte_sel_q <= 1'b0;
      end else if (pop_byte) begin
         byte_sel_q <= !byte_sel_q; // see R17
      end
   end

   // Word count. Pushes happen only in write mode and pops only in read
   // mode, so the two never meet; an eviction keeps the count unchanged.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         count_q <= '0;
      end else if (flush) begin
         count_q <= '0;
      end else if (store && !evict) begin
         count_q <= count_q + ssf_count_t'(1); // see R9
      end else if (pop_word) begin
         count_q <= count_q - ssf_count_t'(1); // see R17
      end
   end

   // Data output register keeps the last byte handed to the host.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         data_out_q <= `SSF_RST_BYTE;
      end else if (flush) begin
         data_out_q <= `SSF_RST_BYTE;
      end else if (pop_byte) begin
         data_out_q <= head_byte; // see R15
      end
   end

   // Skid buffer storage.
   always_ff @(posedge clk_in) begin
      if (skid_push) begin
         skid_mem[skid_wr_q] <= word_data_in;
      end
   end

   // Skid buffer pointers and occupancy.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         skid_wr_q  <= 1'b0;
         skid_rd_q  <= 1'b0;
         skid_cnt_q <= 2'h0;
      end else begin
         if (skid_push) begin
            skid_wr_q <= !skid_wr_q;
         end
         if (drain) begin
            skid_rd_q <= !skid_rd_q;
         end
         if (skid_push && !drain) begin
            skid_cnt_q <= skid_cnt_q + 2'h1;
         end else if (drain && !skid_push) begin
            skid_cnt_q <= skid_cnt_q - 2'h1;
         end
      end
   end

   // Status and control images.
   always_comb begin
      status_byte = 8'h00;
      status_byte[`SSF_STAT_FULL_BIT]   = full; // see R11
      status_byte[`SSF_STAT_WTM_BIT]    = wtm_hit; // see R12
      status_byte[`SSF_STAT_OVR_BIT]    = overrun_q; // see R13
      status_byte[`SSF_STAT_NEMPTY_BIT] = not_empty; // see R14
      status_byte[`SSF_STAT_CNT_HI:`SSF_STAT_CNT_LO] = count_q[`SSF_CNT_W-1:8]; // see R10
      ctrl_byte = 8'h00;
      ctrl_byte[`SSF_CTRL_RD_MODE_BIT]                  = rd_mode_q;
      ctrl_byte[`SSF_CTRL_SIZE_HI:`SSF_CTRL_SIZE_LO]    = size_q;
      ctrl_byte[`SSF_CTRL_POL_HI:`SSF_CTRL_POL_LO]      = policy_q;
   end

   // Read data is registered and valid the cycle after the read strobe.
   // A data read of an empty buffer or outside read mode returns the held
   // byte and pops nothing.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `SSF_ADDR_WTM_TH:   reg_rdata_out <= wtm_q;
            `SSF_ADDR_CTRL:     reg_rdata_out <= ctrl_byte;
            `SSF_ADDR_CNT_LOW:  reg_rdata_out <= count_q[7:0]; // see R9
            `SSF_ADDR_STATUS:   reg_rdata_out <= status_byte;
            `SSF_ADDR_DATA_OUT: reg_rdata_out <= pop_byte ? head_byte : data_out_q; // see R15
            default:            reg_rdata_out <= 8'h00;
         endcase
      end
   end

endmodule

// ==== bench/ssf_sample_fifo_properties.sv ====
// Concurrent checks on the ports of the sample buffer block.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns

module ssf_sample_fifo_properties
#(
   parameter int WORDS_PER_SAMPLE = 6
)(
   input wire logic       clk_in,
   input wire logic       sys_rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic       reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       word_valid_in,
   input wire logic       word_ready_out,
   input wire logic       cmd_rd_mode_in,
   input wire logic       cmd_done_clr_in,
   input wire logic       handshake_sel_in,
   input wire logic       interrupt_line_one_out,
   input wire logic       cmd_done_status_out
);
   // Every check below is cut off while reset is applied.
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   done_excl_a: assert property (!(interrupt_line_one_out && cmd_done_status_out))
      else $error("done shown on both outputs");
   done_set_a: assert property (cmd_rd_mode_in ##1 !handshake_sel_in |-> interrupt_line_one_out)
      else $error("done line missing after readout command");
   done_hold_a: assert property ((interrupt_line_one_out || cmd_done_status_out) && !cmd_done_clr_in
      |=> (interrupt_line_one_out || cmd_done_status_out)) else $error("done dropped without clear");
   done_clr_a: assert property (cmd_done_clr_in && !cmd_rd_mode_in
      |=> !interrupt_line_one_out && !cmd_done_status_out) else $error("done not cleared");
   rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved without a read");
   unmapped_a: assert property (reg_rd_in && (reg_addr_in < 8'h13 || reg_addr_in > 8'h17)
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
   stat_rsvd_a: assert property (reg_rd_in && reg_addr_in == 8'h16 |=> reg_rdata_out[3:2] == 2'h0)
      else $error("status reserved bits set");
   wtm_back_a: assert property (reg_wr_in && !reg_rd_in && reg_addr_in == 8'h13 ##1 !reg_wr_in ##1
      reg_rd_in && !reg_wr_in && reg_addr_in == 8'h13 |=> reg_rdata_out == $past(reg_wdata_in, 3))
      else $error("watermark readback wrong");
   ctrl_cmd_a: assert property (cmd_rd_mode_in ##1 !reg_wr_in ##1 reg_rd_in && reg_addr_in == 8'h14
      |=> reg_rdata_out[7]) else $error("readout bit not set by command");
   ready_fall_a: assert property ($fell(word_ready_out) |-> $past(word_valid_in))
      else $error("ready fell with no word offered");

   // Main scenarios: command, stalled stream, data readout.
   cover property (cmd_rd_mode_in);
   cover property (!word_ready_out);
   cover property (reg_rd_in && reg_addr_in == 8'h17);
endmodule

bind ssf_sample_fifo ssf_sample_fifo_properties #(.WORDS_PER_SAMPLE(WORDS_PER_SAMPLE)) u_props (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
   .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .word_valid_in(word_valid_in), .word_ready_out(word_ready_out), .cmd_rd_mode_in(cmd_rd_mode_in),
   .cmd_done_clr_in(cmd_done_clr_in), .handshake_sel_in(handshake_sel_in),
   .interrupt_line_one_out(interrupt_line_one_out), .cmd_done_status_out(cmd_done_status_out));

// ==== bench/ssf_word_source.sv ====
// Sensor side model: offers queued words with random gaps.
// Assumes the bench pushes words into pend and drives on the falling edge.
`timescale 1ns/1ns

module ssf_word_source (
   input  wire logic        clk_in,
   input  wire logic        word_ready_in,
   output logic             word_valid_out,
   output logic [15:0]      word_data_out
);
   logic [15:0] pend[$];
   logic        took = 1'b0;

   initial word_valid_out = 1'b0;
   initial word_data_out = 16'h0000;

   // Acceptance is judged on the rising edge that samples ready.
   always @(posedge clk_in) took <= word_valid_out && word_ready_in;

   // A word stands until taken; idle data toggles so stale values never match.
   always @(negedge clk_in) begin
      if (word_valid_out && !took) begin
      end else if (pend.size() > 0 && $urandom_range(3) != 0) begin
         word_valid_out <= 1'b1;
         word_data_out <= pend.pop_front();
      end else begin
         word_valid_out <= 1'b0;
         word_data_out <= ~word_data_out;
      end
   end
endmodule

// ==== bench/ssf_sample_fifo_tb.sv ====
// Self-checking bench for the sample buffer, with a queue model of its content.
// Assumes WORDS_PER_SAMPLE of 1 so that capacity equals the sample count.
`timescale 1ns/1ns

module ssf_sample_fifo_tb;
   import ssf_pkg::*;
   logic        clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
   logic        cmd_rd_mode_in = 0, cmd_done_clr_in = 0, handshake_sel_in = 0;
   logic [7:0]  reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, ctrl = 0, last = 0;
   logic        word_valid_in, word_ready_out, line_one, done_st, ovr = 0;
   logic [15:0] word_data_in, q[$];
   int          error_cnt = 0, n_checks = 0, cap = 16, wtm = 0, cyc = 0;

   ssf_sample_fifo #(.WORDS_PER_SAMPLE(1)) DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .word_valid_in(word_valid_in), .word_data_in(word_data_in),
      .word_ready_out(word_ready_out), .cmd_rd_mode_in(cmd_rd_mode_in), .cmd_done_clr_in(cmd_done_clr_in),
      .handshake_sel_in(handshake_sel_in), .interrupt_line_one_out(line_one), .cmd_done_status_out(done_st));
   ssf_word_source src (.clk_in(clk_in), .word_ready_in(word_ready_out), .word_valid_out(word_valid_in),
      .word_data_out(word_data_in));

   // Clock and a hang guard well above the expected run length.
   always #10 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_wr_in = 1;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(negedge clk_in);
      reg_wr_in = 0;
   endtask

   // Read data is settled one cycle after the strobe edge.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_in);
      reg_rd_in = 1;
      reg_addr_in = a;
      @(negedge clk_in);
      reg_rd_in = 0;
      chk($sformatf("reg %h", a), e, reg_rdata_out);
   endtask

   // A change of size or policy empties the buffer and its overrun flag.
   task automatic set_ctrl(input logic [7:0] v);
      reg_wr(8'h14, v);
      if (v[3:0] != ctrl[3:0]) begin
         q.delete();
         ovr = 0;
      end
      ctrl = v;
      cap = 16 << v[3:2];
   endtask

   // Model of storing one word under the current policy.
   task automatic push(input logic [15:0] w);
      if (ctrl[1:0] == 2'h1 || ctrl[1:0] == 2'h2) begin
         if (q.size() >= cap) begin
            ovr = 1;
            if (ctrl[1:0] == 2'h2)
               void'(q.pop_front());
         end
         if (q.size() < cap)
            q.push_back(w);
      end
   endtask

   task automatic send(input int n);
      logic [15:0] w;
      repeat (n) begin
         w = 16'($urandom);
         src.pend.push_back(w);
         push(w);
      end
      while (src.pend.size() != 0 || word_valid_in)
         @(negedge clk_in);
      repeat (4) @(negedge clk_in);
   endtask

   // Reading status clears the sticky overrun flag.
   task automatic check_stat();
      logic [9:0] n;
      n = 10'(q.size());
      rd_chk(8'h15, n[7:0]);
      rd_chk(8'h16, {n >= cap, wtm != 0 && n >= wtm, ovr, n != 0, 2'h0, n[9:8]});
      ovr = 0;
   endtask

   task automatic pop_words(input int n);
      logic [15:0] w;
      repeat (n) begin
         w = q.pop_front();
         rd_chk(8'h17, w[7:0]);
         rd_chk(8'h17, w[15:8]);
         last = w[15:8];
      end
   endtask

   task automatic command(input logic sel);
      handshake_sel_in = sel;
      @(negedge clk_in);
      cmd_rd_mode_in = 1;
      @(negedge clk_in);
      cmd_rd_mode_in = 0;
      chk("done line", {7'h0, !sel}, {7'h0, line_one});
      chk("done bit", {7'h0, sel}, {7'h0, done_st});
   endtask

   // Main sequence: reset values, depth loop, readout, streaming, bypass.
   initial begin
      repeat (6) @(negedge clk_in);
      sys_rst_in = 0;
      void'($urandom(96529));
      for (int a = 8'h13; a <= 8'h18; a++)
         rd_chk(a[7:0], 8'h00);
      wtm = $urandom_range(255);
      reg_wr(8'h13, wtm[7:0]);
      rd_chk(8'h13, wtm[7:0]);
      for (int s = 0; s < 4; s++) begin
         set_ctrl({4'h0, s[1:0], 2'h1});
         wtm = $urandom_range(1, cap + 8);
         reg_wr(8'h13, wtm[7:0]);
         send(cap + 3);
         check_stat();
         check_stat();
      end
      command(1'b0);
      rd_chk(8'h14, 8'h8d);
      pop_words(5);
      check_stat();
      src.pend.push_back(16'h1234);
      src.pend.push_back(16'hbeef);
      repeat (10) @(negedge clk_in);
      check_stat();
      chk("ready", 8'h00, {7'h0, word_ready_out});
      cmd_done_clr_in = 1;
      @(negedge clk_in);
      cmd_done_clr_in = 0;
      chk("done line", 8'h00, {7'h0, line_one});
      set_ctrl(8'h0d);
      push(16'h1234);
      push(16'hbeef);
      repeat (6) @(negedge clk_in);
      check_stat();
      wtm = 0;
      reg_wr(8'h13, 8'h00);
      set_ctrl(8'h02);
      send(20);
      check_stat();
      command(1'b1);
      pop_words(16);
      check_stat();
      rd_chk(8'h17, last);
      set_ctrl(8'h00);
      send(4);
      check_stat();
      set_ctrl(8'h03);
      send(4);
      check_stat();
      wrap_up();
   end
endmodule
